// ### common/adc_readout_pkg.sv
// package: constants and types for the converter conversion and read-out port
package adc_readout_pkg;
  // clock and phase timing in nanoseconds
  localparam int CLK_PERIOD_NS = 50;
  localparam int CONV_FAST_NS = 750;
  localparam int CONV_STD_NS = 1000;
  localparam int CONV_LOWPWR_NS = 1250;
  localparam int ACQ_LOWPWR_NS = 250;
  // least times round up to whole cycles
  localparam logic [7:0] CONV_FAST_CYC = 8'((CONV_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] CONV_STD_CYC = 8'((CONV_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] CONV_LOWPWR_CYC = 8'((CONV_LOWPWR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] ACQ_LOWPWR_CYC = 8'((ACQ_LOWPWR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  // result and serial framing
  localparam int RESULT_W = 16;
  localparam logic [3:0] FIRST_BIT = 4'hF;
  localparam logic [3:0] LAST_BIT = 4'h0;
  localparam logic [1:0] PHASE_FIRST = 2'h0;
  localparam logic [1:0] PHASE_RISE = 2'h1;
  localparam logic [1:0] PHASE_FALL = 2'h3;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] CODING_FLIP = 16'h8000;

  // raw control pins, synchronised as one group
  typedef struct packed {
    logic cnv_n;
    logic pd;
    logic lp;
    logic fast;
    logic ser;
    logic swap;
    logic ob;
    logic ext;
    logic rdc;
    logic inv_sclk;
    logic inv_sync;
    logic cs_n;
    logic rd_n;
    logic ref_off;
    logic buf_off;
  } pins_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_DRAIN = 2'b11,
    ST_ACQ = 2'b10
  } conv_state_type;
endpackage : adc_readout_pkg

// ### design/adc_readout_port.sv
// design: conversion control, parallel and serial result read-out of a 16-bit sampling converter
// Behaviour
// - a started conversion always completes; strobes and power-down cannot abort it
// - low-power mode: start held low when busy falls self-times acquisition, reconverts
// - automatic back-to-back conversion never happens in fast or standard mode
// - low-power mode is low-power select high, fast select low; powers down idle
// - reference off and buffer off pins pick internal, buffered external or direct
// - chip select OR read strobe high floats every data interface output
// - serial select low presents the result on the parallel bus
// - byte order low: low byte on lanes 7..0, high byte on 15..8
// - byte order high: the two bytes swap lanes
// - serial select high shifts 16 bits out, msb first, one per clock
// - each serial bit stays valid across rising and falling serial clock edges
// - clock source low: device makes serial clock and a sync strobe
// - master serial clock and sync polarity can each be inverted
// - read-mode pin picks read after conversion or previous result during conversion
// - master read-after-conversion keeps busy high until all 16 bits are out
// - clock source high: host clock shifts only while select and read are low
// - coding pin picks straight binary or twos complement on every output
// - twos complement is straight binary with the top bit inverted
`timescale 1ns/1ps
`default_nettype none
module adc_readout_port (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic sclk_in_i,
  input wire logic convert_start_n_i,
  input wire logic powerdown_in_i,
  input wire logic lowpower_sel_i,
  input wire logic fastmode_sel_i,
  input wire logic serial_parallel_sel_i,
  input wire logic byte_order_sel_i,
  input wire logic output_coding_sel_i,
  input wire logic clock_source_sel_i,
  input wire logic readmode_chain_in_i,
  input wire logic sclk_invert_i,
  input wire logic sync_invert_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic ref_off_i,
  input wire logic refbuffer_off_i,
  input wire logic [15:0] sample_i,
  output logic busy_o,
  output logic sample_hold_o,
  output logic analog_on_o,
  output logic ref_internal_on_o,
  output logic refbuffer_on_o,
  output logic [15:0] data_o,
  output logic data_oe_n_o,
  output logic serial_out_o,
  output logic serial_oe_n_o,
  output logic sclk_o,
  output logic sync_o,
  output logic master_oe_n_o
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and decoded configuration
  adc_readout_pkg::pins_type pins_raw;
  adc_readout_pkg::pins_type pin_a;
  adc_readout_pkg::pins_type pin_s;
  logic cnv_prev;

  assign pins_raw = '{cnv_n: convert_start_n_i, pd: powerdown_in_i, lp: lowpower_sel_i,
                      fast: fastmode_sel_i, ser: serial_parallel_sel_i, swap: byte_order_sel_i,
                      ob: output_coding_sel_i, ext: clock_source_sel_i, rdc: readmode_chain_in_i,
                      inv_sclk: sclk_invert_i, inv_sync: sync_invert_i, cs_n: cs_n_i, rd_n: rd_n_i,
                      ref_off: ref_off_i, buf_off: refbuffer_off_i};

  // two flip-flops before any logic looks at a pin
  always_ff @(posedge clk_i) begin
    pin_a <= pins_raw;
    pin_s <= pin_a;
    cnv_prev <= reset_i ? 1'b1 : pin_s.cnv_n;
  end

  wire cnv_fall = cnv_prev & ~pin_s.cnv_n;
  wire lowpower = pin_s.lp & ~pin_s.fast;
  wire gate_off = pin_s.cs_n | pin_s.rd_n;
  wire master = pin_s.ser & ~pin_s.ext;
  wire read_after = ~pin_s.rdc;
  wire [7:0] conv_len = pin_s.fast ? adc_readout_pkg::CONV_FAST_CYC :
                        lowpower ? adc_readout_pkg::CONV_LOWPWR_CYC : adc_readout_pkg::CONV_STD_CYC;
  wire [15:0] coded = pin_s.ob ? sample_i : (sample_i ^ adc_readout_pkg::CODING_FLIP);

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer
  adc_readout_pkg::conv_state_type state;
  adc_readout_pkg::conv_state_type next_state;
  logic [7:0] count;
  logic [7:0] next_count;
  logic [15:0] result;
  logic result_tgl;
  logic mactive;
  logic mstart;

  wire count_done = (count == adc_readout_pkg::COUNT_ZERO);
  wire conv_done = (state == adc_readout_pkg::ST_CONV) & count_done;
  wire drain_done = (state == adc_readout_pkg::ST_DRAIN) & ~mactive;
  wire busy_falls = (conv_done & ~(master & read_after)) | drain_done;
  wire auto_go = lowpower & ~pin_s.cnv_n;

  // next state: a running conversion ignores strobes and power-down
  always_comb begin
    next_state = state;
    next_count = count - adc_readout_pkg::COUNT_ONE;
    unique case (state)
      adc_readout_pkg::ST_IDLE: begin
        next_count = count;
        if (cnv_fall & ~pin_s.pd) begin
          next_state = adc_readout_pkg::ST_CONV;
          next_count = conv_len - adc_readout_pkg::COUNT_ONE;
        end
      end
      adc_readout_pkg::ST_CONV: begin
        if (count_done) begin
          next_count = adc_readout_pkg::ACQ_LOWPWR_CYC - adc_readout_pkg::COUNT_ONE;
          if (master & read_after)
            next_state = adc_readout_pkg::ST_DRAIN;
          else if (auto_go)
            next_state = adc_readout_pkg::ST_ACQ;
          else
            next_state = adc_readout_pkg::ST_IDLE;
        end
      end
      adc_readout_pkg::ST_DRAIN: begin
        next_count = adc_readout_pkg::ACQ_LOWPWR_CYC - adc_readout_pkg::COUNT_ONE;
        if (~mactive)
          next_state = auto_go ? adc_readout_pkg::ST_ACQ : adc_readout_pkg::ST_IDLE;
      end
      adc_readout_pkg::ST_ACQ: begin
        if (count_done) begin
          next_state = adc_readout_pkg::ST_CONV;
          next_count = conv_len - adc_readout_pkg::COUNT_ONE;
        end
      end
    endcase
  end

  // state, result latch and busy flag
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= adc_readout_pkg::ST_IDLE;
      count <= adc_readout_pkg::COUNT_ZERO;
      result <= adc_readout_pkg::RESULT_RESET;
      result_tgl <= 1'b0;
      busy_o <= 1'b0;
      sample_hold_o <= 1'b0;
      analog_on_o <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      if (conv_done) begin
        result <= coded;
        result_tgl <= ~result_tgl;
      end
      busy_o <= (next_state == adc_readout_pkg::ST_CONV) | (next_state == adc_readout_pkg::ST_DRAIN);
      sample_hold_o <= (next_state == adc_readout_pkg::ST_CONV);
      analog_on_o <= (next_state == adc_readout_pkg::ST_CONV) | (~pin_s.pd & ~lowpower);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference selection and parallel bus
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ref_internal_on_o <= 1'b0;
      refbuffer_on_o <= 1'b0;
      data_o <= adc_readout_pkg::RESULT_RESET;
      data_oe_n_o <= 1'b1;
    end else begin
      ref_internal_on_o <= ~pin_s.ref_off;
      refbuffer_on_o <= ~pin_s.buf_off;
      data_o <= pin_s.swap ? {result[7:0], result[15:8]} : result;
      data_oe_n_o <= gate_off | pin_s.ser;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master serial shifter: four clocks per bit, data moves while sclk is low
  logic [1:0] mphase;
  logic [3:0] midx;
  logic [15:0] mword;
  wire start_conv = (next_state == adc_readout_pkg::ST_CONV) & (state != adc_readout_pkg::ST_CONV);

  assign mstart = master & ~mactive & ((conv_done & read_after) | (start_conv & ~read_after));

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mactive <= 1'b0;
      mphase <= adc_readout_pkg::PHASE_FIRST;
      midx <= adc_readout_pkg::FIRST_BIT;
      mword <= adc_readout_pkg::RESULT_RESET;
    end else if (mstart) begin
      mactive <= 1'b1;
      mphase <= adc_readout_pkg::PHASE_FIRST;
      midx <= adc_readout_pkg::FIRST_BIT;
      mword <= read_after ? coded : result;
    end else if (mactive) begin
      mphase <= mphase + 2'h1;
      if (mphase == adc_readout_pkg::PHASE_FALL) begin
        mword <= {mword[14:0], 1'b0};
        midx <= midx - 4'h1;
        mactive <= (midx != adc_readout_pkg::LAST_BIT);
      end
    end
  end

  wire sclk_high = mactive & (mphase[0] ^ mphase[1]); // high in phases one and two
  // polarity options are applied last so the timing is unchanged
  assign sclk_o = sclk_high ^ pin_s.inv_sclk;
  assign sync_o = mactive ^ pin_s.inv_sync;
  assign master_oe_n_o = gate_off | ~master;

  ////////////////////////////////////////////////////////////////////////////
  // slave serial shifter on the host clock; the result word is held stable and handed over by toggle
  logic srst_a;
  logic srst;
  logic stgl_a;
  logic stgl;
  logic stgl_seen;
  logic sgate_a;
  logic sgate;
  logic [15:0] sword;

  // data changes on the falling edge, so it is settled at the next rising and falling edge
  // the word reloads on every falling edge while deselected, so a burst clock that missed several
  // results still shows the latest one; a reload waits while the handover flag is moving
  always_ff @(negedge sclk_in_i) begin
    srst_a <= reset_i;
    srst <= srst_a;
    stgl_a <= result_tgl;
    stgl <= stgl_a;
    stgl_seen <= stgl;
    sgate_a <= cs_n_i | rd_n_i;
    sgate <= sgate_a;
    if (srst) begin
      sword <= adc_readout_pkg::RESULT_RESET;
    end else if (sgate) begin
      if (stgl == stgl_seen)
        sword <= result;
    end else begin
      sword <= {sword[14:0], 1'b0};
    end
  end

  assign serial_out_o = master ? mword[15] : sword[15];
  assign serial_oe_n_o = gate_off | ~pin_s.ser;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence conv_ends;
    conv_done ##1 ~busy_o;
  endsequence

  chk_conv_no_abort: assert property ($rose(sample_hold_o) |-> sample_hold_o [*8])
    else $error("conversion cut short");
  chk_auto_restart: assert property ((conv_done & auto_go & ~(master & read_after)) |-> ##1 conv_ends or
      (##1 (state == adc_readout_pkg::ST_ACQ) [*2] ##[1:8] sample_hold_o))
    else $error("low-power mode did not restart");
  chk_no_auto_fast: assert property ((busy_falls & ~lowpower & ~cnv_fall) |=> ~busy_o ##1 ~busy_o)
    else $error("automatic conversion outside low-power mode");
  chk_float_gate: assert property (gate_off & $past(gate_off) |-> data_oe_n_o & master_oe_n_o & serial_oe_n_o)
    else $error("outputs driven while deselected");
  chk_byte_lanes: assert property (~pin_s.swap & $stable(result) & $stable(pin_s.swap) |=> data_o == $past(result))
    else $error("byte lanes wrong");
  chk_byte_swap: assert property (pin_s.swap & $stable(result) & $stable(pin_s.swap)
      |=> data_o == {$past(result[7:0]), $past(result[15:8])})
    else $error("byte swap wrong");
  chk_coding_msb: assert property (conv_done |=> result[15] == ($past(sample_i[15]) ^ ~$past(pin_s.ob)))
    else $error("coding top bit wrong");
  chk_master_frame: assert property (mstart |=> mactive [*8] ##57 ~mactive)
    else $error("master frame not 64 clocks");
  chk_busy_extend: assert property ((state == adc_readout_pkg::ST_DRAIN) & mactive |-> busy_o)
    else $error("busy fell before serial bits were out");
  chk_ref_select: assert property ($past(pin_s.ref_off) & $past(pin_s.buf_off) |-> ~ref_internal_on_o & ~refbuffer_on_o)
    else $error("direct reference selection wrong");
endmodule : adc_readout_port
`default_nettype wire

// ### dv/host_serial_model.sv
// partner: host serial port that clocks the slave serial read-out
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
  input wire logic reset_i,
  input wire logic go_i,
  input wire logic sdata_i,
  output logic sclk_o,
  output logic sel_n_o,
  output logic [31:0] cap_o,
  output logic done_o
);
  // burst clock idling low: runs under reset and per read, silent while reset and go are low
  initial begin
    sclk_o = 1'b0;
    sel_n_o = 1'b1;
    cap_o = 32'h0000_0000;
    done_o = 1'b0;
    forever begin
      wait (reset_i || go_i);
      done_o = 1'b0;
      repeat (reset_i ? 1 : 4) begin
        #6 sclk_o = 1'b1;
        #6 sclk_o = 1'b0;
      end
      if (go_i && !reset_i) begin
        #3 sel_n_o = 1'b0;
        repeat (26) begin
          #3 sclk_o = 1'b1;
          cap_o = {cap_o[30:0], sdata_i};  // sample on the rising edge
          #6 sclk_o = 1'b0;
          #3;
        end
        sel_n_o = 1'b1;
        done_o = 1'b1;
        wait (!go_i);
      end
    end
  end
endmodule : host_serial_model
`default_nettype wire

// ### dv/tb_adc_readout_port.sv
// bench: self-checking testbench of the converter conversion and read-out port
`timescale 1ns/1ps
`default_nettype none
module tb_adc_readout_port;
  logic clk_i;
  logic reset_i;
  logic go;
  logic [15:0] sample, prev, last, mcap, data;
  logic [31:0] rng, hcap;
  logic busy, hold, aon, refi, refb, doe, sout, soe, msclk, msync, moe, hsclk, hsel_n, hdone;
  int n_errors;
  int cmp_count;
  int mcnt;
  int lens [3];
  adc_readout_pkg::pins_type p;
  ////////////////////////////////////////
  // clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // design and host serial port
  adc_readout_port dut (.clk_i(clk_i), .reset_i(reset_i), .sclk_in_i(hsclk), .convert_start_n_i(p.cnv_n),
    .powerdown_in_i(p.pd), .lowpower_sel_i(p.lp), .fastmode_sel_i(p.fast), .serial_parallel_sel_i(p.ser),
    .byte_order_sel_i(p.swap), .output_coding_sel_i(p.ob), .clock_source_sel_i(p.ext),
    .readmode_chain_in_i(p.rdc), .sclk_invert_i(p.inv_sclk), .sync_invert_i(p.inv_sync),
    .cs_n_i(p.ext ? hsel_n : p.cs_n), .rd_n_i(p.ext ? hsel_n : p.rd_n), .ref_off_i(p.ref_off),
    .refbuffer_off_i(p.buf_off), .sample_i(sample), .busy_o(busy), .sample_hold_o(hold), .analog_on_o(aon),
    .ref_internal_on_o(refi), .refbuffer_on_o(refb), .data_o(data), .data_oe_n_o(doe), .serial_out_o(sout),
    .serial_oe_n_o(soe), .sclk_o(msclk), .sync_o(msync), .master_oe_n_o(moe));
  host_serial_model host (.reset_i(reset_i), .go_i(go), .sdata_i(sout), .sclk_o(hsclk), .sel_n_o(hsel_n),
    .cap_o(hcap), .done_o(hdone));
  // master frame capture on the effective rising clock edge while the frame is active
  always @(posedge (msclk ^ p.inv_sclk)) begin
    if (msync ^ p.inv_sync) begin
      mcap = {mcap[14:0], sout};
      mcnt++;
    end
  end
  ////////////////////////////////////////
  // reference model, compare and helpers
  function automatic logic [15:0] expect_word(input int s, input bit ob, input bit sw);
    int v;
    v = ob ? s : (s ^ 32'h0000_8000);
    return sw ? 16'({v[7:0], v[15:8]}) : 16'(v);
  endfunction : expect_word
  function automatic void nx();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
  endfunction : nx
  task automatic close_out();
    if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] got, input logic [15:0] expv);
    cmp_count++;
    if (got !== expv) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, expv);
    end
  endtask : chk
  task automatic wt(input int c);
    repeat (c) @(negedge clk_i);
  endtask : wt
  // one conversion; keep holds the strobe low, poke strobes and powers down mid-conversion
  task automatic conv(input int len, input bit keep, input bit poke);
    int n;
    int w;
    n = 0;
    w = 0;
    prev = last;
    last = sample;
    p.cnv_n = 1'b0;
    wt(2);
    p.cnv_n = !keep;
    while (busy !== 1'b1 && w < 10) begin wt(1); w++; end
    if (poke) begin p.cnv_n = 1'b0; p.pd = 1'b1; end
    while (busy === 1'b1 && n < 400) begin
      wt(1);
      n++;
      if (poke && n == 3) begin p.cnv_n = 1'b1; p.pd = 1'b0; end
    end
    if (len > 0) chk(16'(n), 16'(len));
  endtask : conv
  ////////////////////////////////////////
  // main sequence
  initial begin
    int w;
    int ok;
    p = '0;
    p.cnv_n = 1'b1;
    p.cs_n = 1'b1;
    p.rd_n = 1'b1;
    go = 1'b0;
    sample = 16'h0000;
    last = 16'h0000;
    mcap = 16'h0000;
    rng = 32'h0000_c5e0;
    n_errors = 0;
    cmp_count = 0;
    mcnt = 0;
    lens = '{adc_readout_pkg::CONV_FAST_CYC, adc_readout_pkg::CONV_STD_CYC, adc_readout_pkg::CONV_LOWPWR_CYC};
    reset_i = 1'b1;
    wt(5);
    reset_i = 1'b0;
    chk(16'({busy, doe}), 16'h0001);
    for (int i = 0; i < 4; i++) begin
      p.ref_off = i[0];
      p.buf_off = i[1];
      wt(4);
      chk(16'({refi, refb}), 16'({~i[0], ~i[1]}));
    end
    // parallel reads over every mode, byte order and coding
    for (int i = 0; i < 12; i++) begin
      nx();
      sample = (i == 0) ? 16'h8000 : rng[15:0];
      p.fast = (i % 3 == 0);
      p.lp = (i % 3 == 2);
      p.swap = 1'((i / 3) % 2);
      p.ob = 1'(i / 6);
      p.cs_n = 1'b0;
      p.rd_n = 1'b0;  // read strobe held low through the whole conversion
      wt(4);
      conv(lens[i % 3], 1'b0, 1'b1);
      wt(2);
      chk(data, expect_word(sample, p.ob, p.swap));
      chk(16'(doe), 16'h0000);
      p.cs_n = i[0];
      p.rd_n = ~i[0];
      wt(4);
      chk(16'(doe), 16'h0001);
    end
    // held strobe: self-running in low power only
    p.fast = 1'b0;
    p.lp = 1'b1;
    wt(4);
    conv(lens[2], 1'b1, 1'b0);
    chk(16'(aon), 16'h0000);
    w = 0;
    while (busy !== 1'b1 && w < 20) begin wt(1); w++; end
    chk(16'(w), 16'(adc_readout_pkg::ACQ_LOWPWR_CYC));
    p.cnv_n = 1'b1;
    w = 0;
    while (busy === 1'b1 && w < 100) begin wt(1); w++; end
    p.lp = 1'b0;
    wt(4);
    conv(lens[1], 1'b1, 1'b0);
    wt(30);
    chk(16'(busy), 16'h0000);
    chk(16'(aon), 16'h0001);
    p.cnv_n = 1'b1;
    // master serial: read after, then read previous during, with inversion
    for (int k = 0; k < 2; k++) begin
      nx();
      sample = rng[15:0];
      p.ser = 1'b1;
      p.fast = 1'b1;
      p.swap = 1'b0;
      p.rdc = k[0];
      p.inv_sclk = k[0];
      p.inv_sync = k[0];
      p.cs_n = 1'b0;
      p.rd_n = 1'b0;
      wt(4);
      mcnt = 0;
      conv(k * lens[0], 1'b0, 1'b0);
      if (k == 0) chk(16'(mcnt), 16'h0010);
      w = 0;
      while (mcnt < 16 && w < 200) begin wt(1); w++; end
      chk(mcap, expect_word(k ? prev : last, p.ob, 1'b0));
      chk(16'({moe, soe}), 16'h0000);
      wt(70);
    end
    // slave serial read after conversion
    p.ext = 1'b1;
    p.rdc = 1'b0;
    wt(4);
    conv(lens[0], 1'b0, 1'b0);
    go = 1'b1;
    w = 0;
    while (hdone !== 1'b1 && w < 400) begin wt(1); w++; end
    go = 1'b0;
    ok = 0;
    for (int r = 0; r < 6; r++) if (hcap[25 - r -: 16] === expect_word(last, p.ob, 1'b0)) ok = 1;
    chk(16'(ok), 16'h0001);
    close_out();
  end
  // watchdog
  initial begin
    #1_000_000;
    n_errors++;
    close_out();
  end
endmodule : tb_adc_readout_port
`default_nettype wire
